// ### verilog/zatr_pkg.sv
// Package of constants for the z-axis, thermal and aux result registers
package zatr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] ZATR_IDX_Z_BYTE      = 8'h0A;
    localparam logic [7:0] ZATR_IDX_Z_UPPER     = 8'h12;
    localparam logic [7:0] ZATR_IDX_Z_LOWER     = 8'h13;
    localparam logic [7:0] ZATR_IDX_T_UPPER     = 8'h14;
    localparam logic [7:0] ZATR_IDX_T_LOWER     = 8'h15;
    localparam logic [7:0] ZATR_IDX_A_UPPER     = 8'h16;
    localparam logic [7:0] ZATR_IDX_A_LOWER     = 8'h17;
    localparam logic [7:0] ZATR_IDX_STATUS      = 8'h30;
    localparam logic [7:0] ZATR_IDX_MASK        = 8'h31;
    // Field layout
    localparam int         ZATR_SAMPLE_W        = 14;
    localparam int         ZATR_LOW_POS         = 2;
    localparam logic [7:0] ZATR_RESULT_RESET    = 8'h00;
    localparam logic [2:0] ZATR_MASK_RESET      = 3'h0;
    // Status bits: z ready, thermal new, aux new
    localparam int         ZATR_ST_Z_READY      = 0;
    localparam int         ZATR_ST_T_NEW        = 1;
    localparam int         ZATR_ST_A_NEW        = 2;
    localparam int         ZATR_ST_W            = 3;
endpackage

// ### verilog/zatr_rd_if.sv
// Interface carrying decoded register reads from the bus slave to the core
`timescale 1ns/1ps
`default_nettype none
interface zatr_rd_if;
    logic       rd_pulse;
    logic [7:0] rd_index;
    logic [7:0] rd_data;
    modport slave (output rd_pulse, output rd_index, input rd_data);
    modport core  (input rd_pulse, input rd_index, output rd_data);
endinterface
`default_nettype wire

// ### verilog/zatr_result_byte.sv
// Splits a 14-bit sign-extended sample into its upper and lower byte views
`timescale 1ns/1ps
`default_nettype none
module zatr_result_byte
    import zatr_pkg::*;
#(
    parameter int SAMPLE_W = ZATR_SAMPLE_W
) (
    // Sample in
    input  wire logic [SAMPLE_W-1:0] sample_i,
    // Byte views
    output logic      [7:0]          upper_o,
    output logic      [7:0]          lower_o
);
    // Eight MSBs whole, six LSBs shifted up, reserved bits zero
    assign upper_o = sample_i[SAMPLE_W-1 -: 8];
    assign lower_o = {sample_i[ZATR_LOW_POS*3-1:0], 2'h0};
endmodule
`default_nettype wire

// ### verilog/zatr_readout.sv
// Top: Wishbone slave for the z-axis, thermal and aux result registers
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module zatr_readout
    import zatr_pkg::*;
#(
    parameter int SAMPLE_W = ZATR_SAMPLE_W
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [9:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Sample inputs, each taken when its strobe is high
    input  wire logic [SAMPLE_W-1:0] z_axis_sample_i,
    input  wire logic                z_axis_valid_i,
    input  wire logic [SAMPLE_W-1:0] thermal_sample_i,
    input  wire logic                thermal_valid_i,
    input  wire logic [SAMPLE_W-1:0] aux_conversion_sample_i,
    input  wire logic                aux_conversion_valid_i,
    // Status out
    output logic                     data_ready_o,
    output logic                     irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one-cycle ack, address decode
    zatr_rd_if rd ();
    logic            req;
    logic [7:0]      idx;
    logic            idx_ok;
    logic [31:0]     next_dat;

    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx    = wb_adr_i[9:2];
    assign idx_ok = (wb_adr_i[1:0] == 2'h0);
    assign rd.rd_pulse = req && !wb_we_i && idx_ok;
    assign rd.rd_index = idx;

    // Ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stored samples
    logic [SAMPLE_W-1:0] z_hold;
    logic [SAMPLE_W-1:0] t_hold;
    logic [SAMPLE_W-1:0] a_hold;

    // Only sample strobes load these; bus writes never reach them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            z_hold <= '0;
            t_hold <= '0;
            a_hold <= '0;
        end else begin
            if (z_axis_valid_i) begin
                z_hold <= z_axis_sample_i;
            end
            if (thermal_valid_i) begin
                t_hold <= thermal_sample_i;
            end
            if (aux_conversion_valid_i) begin
                a_hold <= aux_conversion_sample_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte views
    logic [7:0] z_up;
    logic [7:0] z_lo;
    logic [7:0] t_up;
    logic [7:0] t_lo;
    logic [7:0] a_up;
    logic [7:0] a_lo;

    zatr_result_byte #(.SAMPLE_W(SAMPLE_W)) u_z (
        .sample_i (z_hold),
        .upper_o  (z_up),
        .lower_o  (z_lo)
    );
    zatr_result_byte #(.SAMPLE_W(SAMPLE_W)) u_t (
        .sample_i (t_hold),
        .upper_o  (t_up),
        .lower_o  (t_lo)
    );
    zatr_result_byte #(.SAMPLE_W(SAMPLE_W)) u_a (
        .sample_i (a_hold),
        .upper_o  (a_up),
        .lower_o  (a_lo)
    );

    ////////////////////////////////////////////////////////////////////////
    // Paired read tracking: z upper read arms, the very next access decides
    logic pair_armed;
    logic pair_done;

    assign pair_done = rd.rd_pulse && pair_armed
                       && (rd.rd_index == ZATR_IDX_Z_LOWER);

    // Any other access between the two breaks the pair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pair_armed <= 1'b0;
        end else if (req) begin
            pair_armed <= rd.rd_pulse && (rd.rd_index == ZATR_IDX_Z_UPPER);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, mask, interrupt
    logic [ZATR_ST_W-1:0] status;
    logic [ZATR_ST_W-1:0] mask;
    logic [ZATR_ST_W-1:0] events;
    logic [ZATR_ST_W-1:0] w1c;
    logic                 wr_ok;

    assign wr_ok  = req && wb_we_i && idx_ok && wb_sel_i[0];
    assign events = {aux_conversion_valid_i, thermal_valid_i, z_axis_valid_i};
    assign w1c    = (wr_ok && idx == ZATR_IDX_STATUS) ? wb_dat_i[ZATR_ST_W-1:0] : '0;

    // Set beats clear; z ready also clears on the paired read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
        end else begin
            status <= events | (status & ~w1c);
            if (pair_done && !z_axis_valid_i) begin
                status[ZATR_ST_Z_READY] <= 1'b0;
            end
        end
    end

    // Mask and status (write-one-to-clear) are the only writable registers; result writes fall through
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask <= ZATR_MASK_RESET;
        end else if (wr_ok && idx == ZATR_IDX_MASK) begin
            mask <= wb_dat_i[ZATR_ST_W-1:0];
        end
    end

    // Registered outputs, one cycle behind the status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o        <= 1'b0;
            data_ready_o <= 1'b0;
        end else begin
            irq_o        <= |(status & mask);
            data_ready_o <= status[ZATR_ST_Z_READY];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    function automatic logic [7:0] read_byte(input logic [7:0] i);
        unique case (i)
            ZATR_IDX_Z_BYTE:  read_byte = z_up;
            ZATR_IDX_Z_UPPER: read_byte = z_up;
            ZATR_IDX_Z_LOWER: read_byte = z_lo;
            ZATR_IDX_T_UPPER: read_byte = t_up;
            ZATR_IDX_T_LOWER: read_byte = t_lo;
            ZATR_IDX_A_UPPER: read_byte = a_up;
            ZATR_IDX_A_LOWER: read_byte = a_lo;
            ZATR_IDX_STATUS:  read_byte = {5'h00, status};
            ZATR_IDX_MASK:    read_byte = {5'h00, mask};
            default:          read_byte = ZATR_RESULT_RESET;
        endcase
    endfunction

    assign rd.rd_data = read_byte(idx);

    // Unmapped or misaligned reads answer zero
    always_comb begin
        next_dat = 32'h0000_0000;
        if (req && !wb_we_i && idx_ok) begin
            next_dat = {24'h00_0000, rd.rd_data};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= next_dat;
        end
    end
endmodule
`default_nettype wire

// ### verification/zatr_sva.sv
// Checker for the result register slave
`timescale 1ns/1ps
`default_nettype none
module zatr_sva (
    // Watched ports
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        z_axis_valid_i,
    input wire logic        data_ready_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request taken this cycle
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Pair steps: upper read, then lower read with no new z sample
    sequence up_rd;
        req && !wb_we_i && wb_adr_i == 10'h048;
    endsequence
    sequence lo_rd;
        req && !wb_we_i && wb_adr_i == 10'h04C && !z_axis_valid_i;
    endsequence
    ack_resp_a: assert property (req |=> wb_ack_o) else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper bits set");
    resv_zero_a: assert property (req && !wb_we_i &&
        wb_adr_i inside {10'h04C, 10'h054, 10'h05C} |=> wb_dat_o[1:0] == 2'h0)
        else $error("reserved bits set");
    wr_zero_a: assert property (req && wb_we_i |=> wb_dat_o == 32'h0)
        else $error("write returned data");
    rdy_set_a: assert property (z_axis_valid_i |-> ##2 data_ready_o)
        else $error("ready not set");
    rst_clear_a: assert property ($fell(rst_i) |-> !wb_ack_o && !data_ready_o)
        else $error("not cleared by reset");
    wr_keep_a: assert property (data_ready_o && req && wb_we_i &&
        wb_adr_i[9:2] != 8'h30 |=> data_ready_o [*2]) else $error("write cleared ready");
    pair_clr_a: assert property (up_rd ##1 wb_ack_o ##1 !wb_cyc_i ##1 lo_rd
        |-> ##2 !data_ready_o) else $error("pair read kept ready");
endmodule
bind zatr_readout zatr_sva chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .z_axis_valid_i, .data_ready_o);
`default_nettype wire

// ### verification/zatr_host.sv
// Host model that reaches the result registers over classic Wishbone
`timescale 1ns/1ps
`default_nettype none
module zatr_host (
    // Clock
    input  wire logic        clk_i,
    // Bus master side
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [9:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    // Idle bus at time zero
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // One cycle; released address and write data invert so stale values never look valid
    task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= {idx, 2'h0};
        sel_o <= 4'hF;
        dat_o <= wd;
        // Look mid-cycle so ack and data are settled, then act on the edge
        do @(negedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i;
        @(posedge clk_i);
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~adr_o;
        dat_o <= ~dat_o;
    endtask
    // Upper byte, then lower byte with nothing between
    task automatic zpair(output logic [7:0] up, output logic [7:0] lo);
        logic [31:0] d;
        acc(1'b0, 8'h12, 32'h0, d);
        up = d[7:0];
        acc(1'b0, 8'h13, 32'h0, d);
        lo = d[7:0];
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the result register slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [13:0] zs = '0, ts = '0, ads = '0;
    logic        zv = 1'b0, tv = 1'b0, av = 1'b0;
    logic        cyc, stb, we, ack, rdy, irq;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, d;
    logic [7:0]  u, l;
    int          mismatches = 0, tests_run = 0;
    logic [7:0]  regs [7] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h0A};
    // Rows: sample, expected upper byte, expected lower byte
    logic [29:0] rows [4] = '{{14'h3FFF, 8'hFF, 8'hFC}, {14'h2001, 8'h80, 8'h04},
                              {14'h1555, 8'h55, 8'h54}, {14'h0ABC, 8'h2A, 8'hF0}};
    zatr_readout dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .z_axis_sample_i(zs), .z_axis_valid_i(zv), .thermal_sample_i(ts), .thermal_valid_i(tv),
        .aux_conversion_sample_i(ads), .aux_conversion_valid_i(av), .data_ready_o(rdy),
        .irq_o(irq));
    zatr_host h (.clk_i, .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        h.acc(1'b0, i, 32'h0, d);
        chk(d[7:0], e);
    endtask
    // One valid pulse on all three sources, then let ready settle
    task automatic load(input logic [13:0] z, input logic [13:0] t, input logic [13:0] a);
        @(posedge clk_i);
        zs <= z;
        ts <= t;
        ads <= a;
        {zv, tv, av} <= 3'h7;
        @(posedge clk_i);
        {zv, tv, av} <= 3'h0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #100us;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) rd(regs[i], 8'h00);
        @(negedge clk_i);
        chk({6'h0, rdy, irq}, 8'h00);
        $display("reset test done");
        // Rotate rows so a swapped source shows up
        for (int i = 0; i < 4; i++) begin
            load(rows[i][29:16], rows[(i+1)%4][29:16], rows[(i+2)%4][29:16]);
            h.zpair(u, l);
            chk(u, rows[i][15:8]);
            chk(l, rows[i][7:0]);
            rd(8'h0A, rows[i][15:8]);
            rd(8'h14, rows[(i+1)%4][15:8]);
            rd(8'h15, rows[(i+1)%4][7:0]);
            rd(8'h16, rows[(i+2)%4][15:8]);
            rd(8'h17, rows[(i+2)%4][7:0]);
        end
        $display("row test done");
        // Broken pair and writes must keep ready and samples
        load(14'h1234, 14'h0, 14'h0155);
        rd(8'h12, 8'h48);
        rd(8'h14, 8'h00);
        rd(8'h13, 8'hD0);
        for (int i = 0; i < 6; i++) h.acc(1'b1, regs[i], 32'hFFFF_FFFF, d);
        @(negedge clk_i);
        chk({7'h0, rdy}, 8'h01);
        h.zpair(u, l);
        repeat (2) @(negedge clk_i);
        chk(u, 8'h48);
        chk({7'h0, rdy}, 8'h00);
        $display("pair test done");
        // Interrupt masked, unmasked, cleared; unmapped read gives zero
        chk({7'h0, irq}, 8'h00);
        rd(8'h30, 8'h06);
        h.acc(1'b1, 8'h31, 32'h2, d);
        repeat (2) @(negedge clk_i);
        chk({7'h0, irq}, 8'h01);
        h.acc(1'b1, 8'h30, 32'h2, d);
        repeat (2) @(negedge clk_i);
        chk({7'h0, irq}, 8'h00);
        rd(8'h3F, 8'h00);
        $display("irq test done");
        stop_test();
    end
endmodule
`default_nettype wire
